// ==== rcsc_defines.vh ====
`ifndef RCSC_DEFINES_VH
`define RCSC_DEFINES_VH

// Register byte addresses on the APB
`define RCSC_ADDR_STATUS 12'h000
`define RCSC_ADDR_CTRL 12'h004
`define RCSC_ADDR_DEBUG 12'h008

// Reset cause bit positions
`define RCSC_BIT_POWER_ON 7
`define RCSC_BIT_PIN 6
`define RCSC_BIT_WATCHDOG 5
`define RCSC_BIT_BAD_OPCODE 4
`define RCSC_BIT_BAD_ADDRESS 3
`define RCSC_BIT_CLOCK_LOSS 2
`define RCSC_BIT_LOW_VOLTAGE 1

// Control register bit positions
`define RCSC_CTRL_WDOG_EN 0
`define RCSC_CTRL_STOP_ALLOW 1
`define RCSC_CTRL_BACKGROUND_ENTRY_INSTR_ALLOW 2
`define RCSC_CTRL_RESET 8'h01

// Watchdog service key bytes
`define RCSC_KEY_FIRST 8'h55
`define RCSC_KEY_SECOND 8'hAA

// Reset and cause encodings
`define RCSC_STATUS_POR 8'h82
`define RCSC_STATUS_ZERO 8'h00
`define RCSC_WDOG_TIMEOUT 16'hFFFF

`endif

// ==== rcsc_watchdog_service.v ====
`timescale 1ns/100ps
`include "rcsc_defines.vh"

module rcsc_watchdog_service (
	input wire pclk, // System clock
	input wire presetn, // Async reset, active low
	input wire wr_strobe, // One-cycle write to status address
	input wire [7:0] wr_byte, // Written byte
	input wire wdog_enable, // Watchdog enabled
	output reg service_pulse, // Key sequence completed
	output reg bad_write_pulse // Non-key value written while watchdog enabled
);
	reg key_armed;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_armed <= 1'b0;
			service_pulse <= 1'b0;
			bad_write_pulse <= 1'b0;
		end else begin
			service_pulse <= 1'b0;
			bad_write_pulse <= 1'b0;
			if (wr_strobe) begin
				if (wr_byte == `RCSC_KEY_FIRST) begin
					key_armed <= 1'b1;
				end else if (wr_byte == `RCSC_KEY_SECOND) begin
					service_pulse <= key_armed;
					key_armed <= 1'b0;
				end else begin
					key_armed <= 1'b0;
					bad_write_pulse <= wdog_enable;
				end
			end
		end
	end
endmodule // rcsc_watchdog_service

// ==== rcsc_reset_cause.v ====
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
`include "rcsc_defines.vh"

module rcsc_reset_cause #(
	parameter WDOG_WIDTH = 16, // Watchdog counter width
	parameter [15:0] WDOG_TIMEOUT = `RCSC_WDOG_TIMEOUT // Cycles to timeout
) (
	input wire pclk, // System clock
	input wire presetn, // Async reset, active low (power-on)
	input wire [11:0] paddr, // APB address
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output wire pslverr, // APB error
	input wire ext_reset_n, // External reset pin, active low
	input wire low_voltage_det, // Supply below threshold
	input wire clock_loss_det, // Clock monitor lost clock
	input wire bad_opcode_det, // Unimplemented opcode fetched
	input wire stop_instr_det, // Stop instruction executed
	input wire background_entry_instr_instr_det, // Background entry instruction executed
	input wire bad_address_det, // Unimplemented memory access
	output wire system_reset // Reset request to the chip, active high
);
	reg [7:0] reset_cause_status;
	reg [7:0] ctrl;
	reg debug_force_reset_bit;
	reg [WDOG_WIDTH-1:0] wdog_count;
	reg in_reset;
	reg [1:0] pin_sync;
	reg [1:0] lv_sync;
	reg [1:0] loc_sync;
	reg [1:0] op_sync;
	reg [1:0] stop_sync;
	reg [1:0] background_entry_instr_sync;
	reg [1:0] ad_sync;
	reg [7:0] next_status;
	reg [31:0] next_rdata;

	wire access = psel && penable;
	wire wr_status = access && pwrite && (paddr == `RCSC_ADDR_STATUS);
	wire wr_ctrl = access && pwrite && (paddr == `RCSC_ADDR_CTRL);
	wire wr_debug = access && pwrite && (paddr == `RCSC_ADDR_DEBUG);
	wire watchdog_enable_bit = ctrl[`RCSC_CTRL_WDOG_EN];
	wire stop_allow_bit = ctrl[`RCSC_CTRL_STOP_ALLOW];
	wire background_mode_allow_bit = ctrl[`RCSC_CTRL_BACKGROUND_ENTRY_INSTR_ALLOW];
	wire service_pulse;
	wire bad_write_pulse;
	wire wdog_expired;
	wire pin_src;
	wire opcode_src;
	wire address_src;
	wire any_src;

	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Every asynchronous source goes through two flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync <= 2'h0;
			lv_sync <= 2'h0;
			loc_sync <= 2'h0;
			op_sync <= 2'h0;
			stop_sync <= 2'h0;
			background_entry_instr_sync <= 2'h0;
			ad_sync <= 2'h0;
		end else begin
			pin_sync <= {pin_sync[0], ~ext_reset_n};
			lv_sync <= {lv_sync[0], low_voltage_det};
			loc_sync <= {loc_sync[0], clock_loss_det};
			op_sync <= {op_sync[0], bad_opcode_det};
			stop_sync <= {stop_sync[0], stop_instr_det};
			background_entry_instr_sync <= {background_entry_instr_sync[0], background_entry_instr_instr_det};
			ad_sync <= {ad_sync[0], bad_address_det};
		end
	end

	rcsc_watchdog_service u_service (
		.pclk(pclk),
		.presetn(presetn),
		.wr_strobe(wr_status),
		.wr_byte(pwdata[7:0]),
		.wdog_enable(watchdog_enable_bit),
		.service_pulse(service_pulse),
		.bad_write_pulse(bad_write_pulse)
	);

	assign wdog_expired = watchdog_enable_bit && (wdog_count == WDOG_TIMEOUT[WDOG_WIDTH-1:0]);
	assign pin_src = pin_sync[1];
	assign opcode_src = op_sync[1] || (stop_sync[1] && !stop_allow_bit)
		|| (background_entry_instr_sync[1] && !background_mode_allow_bit);
	assign address_src = ad_sync[1];
	assign any_src = pin_src || wdog_expired || bad_write_pulse || opcode_src || address_src
		|| loc_sync[1] || lv_sync[1] || debug_force_reset_bit;
	assign system_reset = in_reset;

	// Watchdog counter, restarted by the key sequence
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_count <= {WDOG_WIDTH{1'b0}};
		end else if (!watchdog_enable_bit || service_pulse || in_reset) begin
			wdog_count <= {WDOG_WIDTH{1'b0}};
		end else if (!wdog_expired) begin
			wdog_count <= wdog_count + 1'b1;
		end
	end

	// Cause image captured at reset entry
	always @* begin
		next_status = `RCSC_STATUS_ZERO;
		if (lv_sync[1]) begin
			next_status[`RCSC_BIT_POWER_ON] = reset_cause_status[`RCSC_BIT_POWER_ON];
			next_status[`RCSC_BIT_LOW_VOLTAGE] = 1'b1;
		end else if (loc_sync[1]) begin
			next_status[`RCSC_BIT_CLOCK_LOSS] = 1'b1;
		end else if (!debug_force_reset_bit) begin
			next_status[`RCSC_BIT_PIN] = pin_src;
			next_status[`RCSC_BIT_WATCHDOG] = wdog_expired || bad_write_pulse;
			next_status[`RCSC_BIT_BAD_OPCODE] = opcode_src;
			next_status[`RCSC_BIT_BAD_ADDRESS] = address_src;
		end
	end

	// Status only changes on reset entry, never on a bus write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_cause_status <= `RCSC_STATUS_POR;
			in_reset <= 1'b0;
		end else begin
			in_reset <= any_src;
			if (any_src && !in_reset) begin
				reset_cause_status <= next_status;
			end
		end
	end

	// Control registers return to defaults on any chip reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `RCSC_CTRL_RESET;
			debug_force_reset_bit <= 1'b0;
		end else if (in_reset) begin
			ctrl <= `RCSC_CTRL_RESET;
			debug_force_reset_bit <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= {5'h00, pwdata[2:0]};
			end
			if (wr_debug) begin
				debug_force_reset_bit <= pwdata[0];
			end
		end
	end

	always @* begin
		next_rdata = 32'h00000000;
		case (paddr)
			`RCSC_ADDR_STATUS: next_rdata = {24'h000000, reset_cause_status[7:1], 1'b0};
			`RCSC_ADDR_CTRL: next_rdata = {24'h000000, ctrl};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_rdata;
		end
	end
endmodule // rcsc_reset_cause

// ==== rcsc_reset_cause_asserts.sv ====
`timescale 1ns/100ps
module rcsc_reset_cause_asserts (
	input wire pclk, // Clock
	input wire presetn, // Reset
	input wire [11:0] paddr, // Address
	input wire psel, // Select
	input wire penable, // Enable
	input wire pwrite, // Direction
	input wire [31:0] prdata, // Read data
	input wire pready, // Ready
	input wire pslverr, // Error
	input wire ext_reset_n, // Pin
	input wire low_voltage_det, // Low supply
	input wire clock_loss_det, // Clock lost
	input wire bad_opcode_det, // Bad opcode
	input wire bad_address_det, // Bad address
	input wire system_reset // Reset out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = psel && !penable && !pwrite;
	a_bus_ok: assert property (pready && !pslverr) else $error("bus answer");
	a_rdata_hold: assert property (!$past(rd) |-> $stable(prdata)) else $error("prdata");
	a_status_pad: assert property (rd && paddr == 12'h000 |=> prdata[31:8] == 24'h000000
		&& !prdata[0]) else $error("pad");
	a_misc_zero: assert property (rd && paddr > 12'h004 |=> prdata == 32'h00000000)
		else $error("read");
	a_pin_reset: assert property ($fell(ext_reset_n) |-> ##[2:4] system_reset) else $error("pin");
	a_volt_reset: assert property ($rose(low_voltage_det) |-> ##[2:4] system_reset) else $error("lv");
	a_loss_reset: assert property ($rose(clock_loss_det) |-> ##[2:4] system_reset) else $error("lc");
	a_addr_reset: assert property ($rose(bad_address_det) |-> ##[2:4] system_reset) else $error("ad");
	a_op_reset: assert property ($rose(bad_opcode_det) |-> ##[2:4] system_reset) else $error("op");
	c_reset: cover property ($rose(system_reset));
	c_read: cover property (rd && paddr == 12'h000);
	c_write: cover property (psel && penable && pwrite && paddr == 12'h000);
endmodule // rcsc_reset_cause_asserts
bind rcsc_reset_cause rcsc_reset_cause_asserts i_chk (.*);

// ==== test_reset_cause_status_capture.sv ====
`timescale 1ns/100ps
module test_reset_cause_status_capture;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q[$];
	logic pready, pslverr, system_reset;
	logic [6:0] srcs = 7'h00;
	logic [7:0] b;
	int n_errors = 0, n_tests = 0;
	logic [6:0] ts[9] = '{7'h01, 7'h40, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h24, 7'h60};
	logic [7:0] te[9] = '{8'h82, 8'h40, 8'h04, 8'h10, 8'h10, 8'h10, 8'h08, 8'h18, 8'h48};
	always #5 pclk = ~pclk;
	// Short timeout keeps the watchdog runs brief
	rcsc_reset_cause #(.WDOG_TIMEOUT(16'h00C8)) i_dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_reset_n(~srcs[6]),
		.low_voltage_det(srcs[0]), .clock_loss_det(srcs[1]), .bad_opcode_det(srcs[2]),
		.stop_instr_det(srcs[3]), .background_entry_instr_instr_det(srcs[4]), .bad_address_det(srcs[5]),
		.system_reset(system_reset));
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			q.push_back(d);
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	always @(posedge pclk) if (psel && penable && pready && !pwrite)
		chk("prdata", q.pop_front(), prdata);
	task rst(input logic e, input logic [7:0] st, input int n);
		for (int i = 0; i < n && system_reset !== 1'b1; i++) @(posedge pclk);
		chk("system_reset", {31'h0, e}, {31'h0, system_reset});
		for (int i = 0; i < 50 && system_reset !== 1'b0; i++) @(posedge pclk);
		apb(0, 12'h000, {24'h0, st});
	endtask
	task pulse(input logic [6:0] s);
		srcs <= s;
		repeat (4) @(posedge pclk);
		srcs <= 7'h00;
	endtask
	task give_verdict;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		give_verdict;
	end
	initial begin
		void'($urandom(32'hAD9284D3));
		repeat (12) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h000, 32'h82);
		apb(0, 12'h004, 32'h01);
		apb(0, 12'h008, 32'h00);
		apb(0, 12'h00C + 12'($urandom_range(900) * 4), 32'h00);
		b = 8'($urandom);
		if (b == 8'h55 || b == 8'hAA)
			b = 8'h00;
		for (int k = 0; k < 9; k++) begin
			pulse(ts[k]);
			rst(1, te[k], 10);
			if (k == 0) begin
				apb(1, 12'h000, 32'h55);
				apb(1, 12'h000, 32'hAA);
				rst(0, 8'h82, 10);
				apb(1, 12'h000, {24'h0, b});
				rst(1, 8'h20, 10);
			end
		end
		apb(1, 12'h004, 32'h07);
		pulse(7'h18);
		rst(0, 8'h48, 10);
		apb(1, 12'h008, 32'h01);
		rst(1, 8'h00, 10);
		apb(1, 12'h004, 32'h00);
		rst(0, 8'h00, 300);
		apb(1, 12'h004, 32'h01);
		rst(1, 8'h20, 300);
		repeat (150) @(posedge pclk);
		apb(1, 12'h000, 32'h55);
		apb(1, 12'h000, 32'hAA);
		rst(0, 8'h20, 100);
		give_verdict;
	end
endmodule // test_reset_cause_status_capture
